/* cwr_pkg.sv */
// Constants, register map and state type for the configuration word reset controller
package cwr_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 25;
  localparam int LF_HZ = 31_000;
  localparam int LF_DIV = CLK_HZ / LF_HZ;
  localparam int PUT_MS = 64;
  localparam int PUT_TICKS = PUT_MS * LF_HZ / 1000;
  localparam int GLITCH_NS = 2000;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  // Register byte offsets
  localparam logic [7:0] A_CFG1 = 8'h00;
  localparam logic [7:0] A_CFG2 = 8'h04;
  localparam logic [7:0] A_PWR = 8'h08;
  localparam logic [7:0] A_WDC = 8'h0C;
  localparam logic [7:0] A_UNLK = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  // Configuration word one fields
  localparam int B_SWO = 10;
  localparam int B_BORM = 8;
  localparam int B_DPROT = 7;
  localparam int B_PPROT = 6;
  localparam int B_PINSEL = 5;
  localparam int B_PWRTN = 4;
  localparam int B_WDGCFG = 3;
  localparam int B_OSC = 0;
  // Configuration word two fields
  localparam int B_SWP = 9;
  localparam int B_BORLV = 8;
  localparam logic [13:0] CFG2_WMASK = 14'h0700;
  // Power control register fields
  localparam int B_SBOR = 4;
  localparam int B_PORF = 1;
  localparam int B_BORF = 0;
  localparam logic [13:0] CFG_RST = 14'h3FFF;
  localparam logic SBOR_RST = 1'b1;
  // Brown-out modes
  localparam logic [1:0] BOR_ON = 2'h3;
  localparam logic [1:0] BOR_RUN = 2'h2;
  localparam logic [1:0] BOR_SW = 2'h1;
  // Oscillator codes
  localparam logic [2:0] OSC_RC = 3'h7;
  localparam logic [2:0] OSC_RC_IO = 3'h6;
  localparam logic [2:0] OSC_INT = 3'h5;
  localparam logic [2:0] OSC_INTIO = 3'h4;
  localparam logic [2:0] OSC_EC = 3'h3;
  // Self-write protection limits
  localparam logic [12:0] WL_4K_00 = 13'h07FF;
  localparam logic [12:0] WL_4K_01 = 13'h03FF;
  localparam logic [12:0] WL_8K_00 = 13'h0FFF;
  localparam logic [12:0] WL_8K_01 = 13'h07FF;
  localparam logic [12:0] WL_10 = 13'h00FF;
  localparam logic [12:0] TOP_4K = 13'h0FFF;
  localparam logic [12:0] TOP_8K = 13'h1FFF;
  typedef enum logic [1:0] {ST_RESET = 2'b00, ST_BORW = 2'b01, ST_PUT = 2'b10, ST_RUN = 2'b11} cwr_state_t;
endpackage : cwr_pkg

/* cwr_reset_control.sv */
// Configuration word decode and reset sequencing with an AXI4-Lite register slave
`timescale 1ns/1ps
// Contract
// - Brown-out mode 11 on, 10 on except Sleep, 01 software bit, 00 off.
// - Data protect bit 0 read-protects data memory, 1 leaves it open.
// - Program protect bit 0 read-protects program memory, 1 leaves it open.
// - Data protection turned off erases the whole data EEPROM.
// - Program protection turned off erases all program memory.
// - Pin select 1 makes the pin active-low reset; 0 plain input, reset inactive.
// - Weak pull-up is on while the pin acts as reset input.
// - Power-up timer enable is active low.
// - Brown-out enable and power-up timer enable decode independently.
// - Watchdog config 1 runs always; 0 leaves it to the software enable.
// - Oscillator codes 111 to 100 select RC and internal variants.
// - Pin reset in internal or RC mode stops the internal oscillator.
// - Switchover bit 1 enables clock switchover, 0 disables it.
// - 4K variant self-write field protects 07FF, 03FF, 00FF or nothing.
// - 8K variant self-write field protects 0FFF, 07FF or 00FF.
// - Brown-out level bit 1 selects 4.0V, 0 selects 2.1V.
// - All resets but watchdog wake-up load the register reset state.
// - Reset-insensitive registers change only at power-on.
// - Short low glitches on the reset pin are filtered out.
// - Watchdog reset never drives the reset pin low.
// - With brown-out enabled, reset holds until supply is above trip.
// - Enabled power-up timer holds reset 64 ms after power-on or brown-out.
// - Power control bit 4 enables brown-out in software mode.
module cwr_reset_control import cwr_pkg::*; #(
  parameter bit LARGE_ARRAY = 1'b0,
  parameter int LF_DIV_P = cwr_pkg::LF_DIV,
  parameter int PUT_TICKS_P = cwr_pkg::PUT_TICKS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Reset pin, five signals
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  output logic reset_pin_pullup,
  output logic pin_digital_in,
  // Supply and core events
  input wire logic power_on_event,
  input wire logic brownout_ok,
  input wire logic sleep_mode,
  input wire logic watchdog_timeout,
  // Flash self-write check
  input wire logic [12:0] flash_wr_addr,
  output logic flash_wr_ok,
  // Core reset and clock controls
  output logic core_reset_n,
  output logic regs_reset,
  output logic insensitive_hold,
  output logic watchdog_wake,
  output logic brownout_enable,
  output logic brownout_level_high,
  output logic watchdog_enable,
  output logic osc_stop,
  output logic osc_internal,
  output logic osc_clkout,
  output logic osc1_io,
  output logic osc2_io,
  output logic clock_switchover_enable,
  output logic data_read_protect,
  output logic prog_read_protect,
  output logic eeprom_erase,
  output logic prog_erase
);
  import cwr_pkg::*;

  if (LF_DIV_P < 2 || LF_DIV_P > 4096 || PUT_TICKS_P < 1 || PUT_TICKS_P > 4095) begin : g_chk
    $error("cwr_reset_control: divider or timer count out of range");
  end

  // Register state
  logic [13:0] cfg1_q, cfg2_q;
  logic sbor_q, porf_q, borf_q, swdt_q, unlock_q;
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [1:0] bresp_q, rresp_q;
  cwr_state_t state_q;
  logic [11:0] lf_cnt_q, put_cnt_q;
  logic [6:0] pin_cnt_q;
  logic pin_rst_q, cause_put_q;
  logic [31:0] rd_word;
  logic [1:0] cause_q;
  // Registered outputs
  logic core_rst_n_q, regs_rst_q, ins_hold_q, wake_q, bor_en_q, bor_hi_q, wdt_en_q;
  logic osc_stop_q, osc_int_q, osc_clko_q, osc1_io_q, osc2_io_q, swo_q;
  logic dprot_q, pprot_q, ee_erase_q, pg_erase_q, pullup_q, din_q, wr_ok_q;

  // Bus decode
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire do_read = s_arvalid && !rvalid_q;
  wire wr_known = awaddr_q inside {A_CFG1, A_CFG2, A_PWR, A_WDC, A_UNLK, A_STAT};
  wire rd_known = s_araddr inside {A_CFG1, A_CFG2, A_PWR, A_WDC, A_UNLK, A_STAT};
  wire [1:0] be_lo = s_wstrb[1:0];
  wire cfg_we = do_write && unlock_q;
  wire cfg1_we = cfg_we && awaddr_q == A_CFG1;
  wire cfg2_we = cfg_we && awaddr_q == A_CFG2;
  wire pwr_we = do_write && awaddr_q == A_PWR;
  wire [13:0] cfg1_d = cfg1_we ? wdata_q[13:0] : cfg1_q;
  wire [13:0] cfg2_d = cfg2_we ? ((wdata_q[13:0] & CFG2_WMASK) | ~CFG2_WMASK) : cfg2_q;

  // Configuration decode
  wire [1:0] bor_mode = cfg1_q[B_BORM +: 2];
  wire [2:0] osc_sel = cfg1_q[B_OSC +: 3];
  wire [1:0] swp = cfg2_q[B_SWP +: 2];
  wire pin_is_reset = cfg1_q[B_PINSEL];
  wire bor_en_d = (bor_mode == BOR_ON) || (bor_mode == BOR_RUN && !sleep_mode) ||
                  (bor_mode == BOR_SW && sbor_q);
  wire put_en = !cfg1_q[B_PWRTN];
  wire wdt_en_d = cfg1_q[B_WDGCFG] || swdt_q;
  wire rc_mode = osc_sel == OSC_RC || osc_sel == OSC_RC_IO;
  wire int_mode = osc_sel == OSC_INT || osc_sel == OSC_INTIO;
  wire clko_d = osc_sel == OSC_RC || osc_sel == OSC_INT;
  wire osc2_io_d = osc_sel == OSC_RC_IO || osc_sel == OSC_INTIO || osc_sel == OSC_EC;
  wire osc1_io_d = int_mode;
  wire bor_trip = bor_en_q && !brownout_ok;
  wire wdt_reset = watchdog_timeout && wdt_en_q && !sleep_mode;
  wire wdt_wake = watchdog_timeout && wdt_en_q && sleep_mode;

  // Self-write protection window
  wire [12:0] top = LARGE_ARRAY ? TOP_8K : TOP_4K;
  wire [12:0] lim00 = LARGE_ARRAY ? WL_8K_00 : WL_4K_00;
  wire [12:0] lim01 = LARGE_ARRAY ? WL_8K_01 : WL_4K_01;
  wire [12:0] lim = swp == 2'b00 ? lim00 : (swp == 2'b01 ? lim01 : WL_10);
  wire wr_ok_d = flash_wr_addr <= top && (swp == 2'b11 || flash_wr_addr > lim);

  // Reset pin filter: only a low lasting the full count counts
  wire pin_low = pin_is_reset && !reset_pin_in;
  wire pin_full = pin_cnt_q == 7'(GLITCH_CYC);
  wire [6:0] pin_cnt_d = !pin_low ? 7'h00 : (pin_full ? pin_cnt_q : pin_cnt_q + 7'h01);
  wire any_reset = power_on_event || pin_rst_q || wdt_reset || bor_trip;

  // Low-frequency tick for the power-up timer
  wire lf_tick = lf_cnt_q == 12'(LF_DIV_P - 1);
  wire put_done = put_cnt_q == 12'(PUT_TICKS_P);

  // Sequencer next state
  cwr_state_t state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN: if (any_reset) state_d = ST_RESET;
      ST_RESET: if (!power_on_event && !pin_rst_q) state_d = ST_BORW;
      ST_BORW: begin
        if (power_on_event || pin_rst_q) state_d = ST_RESET;
        else if (!bor_trip) state_d = (put_en && cause_put_q) ? ST_PUT : ST_RUN;
      end
      ST_PUT: begin
        if (power_on_event || pin_rst_q) state_d = ST_RESET;
        else if (bor_trip) state_d = ST_BORW;
        else if (put_done) state_d = ST_RUN;
      end
    endcase
  end

  // Bus channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      bresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_wdata;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? 2'h0 : 2'h2;
      end else if (s_bready) begin
        bvalid_q <= 1'b0;
      end
      if (do_read) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_known ? 2'h0 : 2'h2;
        rdata_q <= rd_word;
      end else if (s_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Read mux; bits above each register read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_araddr)
      A_CFG1: rd_word[13:0] = cfg1_q;
      A_CFG2: rd_word[13:0] = cfg2_q;
      A_PWR: rd_word[B_SBOR] = sbor_q;
      A_WDC: rd_word[0] = swdt_q;
      A_UNLK: rd_word[0] = unlock_q;
      A_STAT: rd_word[5:0] = {cause_q, core_rst_n_q, pin_rst_q, state_q};
      default: rd_word = 32'h0000_0000;
    endcase
    if (s_araddr == A_PWR) begin
      rd_word[B_PORF] = porf_q;
      rd_word[B_BORF] = borf_q;
    end
  end

  // Software registers; config words change only while unlocked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg1_q <= CFG_RST;
      cfg2_q <= CFG_RST;
      sbor_q <= SBOR_RST;
      swdt_q <= 1'b0;
      unlock_q <= 1'b0;
      porf_q <= 1'b0;
      borf_q <= 1'b0;
      ee_erase_q <= 1'b0;
      pg_erase_q <= 1'b0;
    end else begin
      cfg1_q <= cfg1_d;
      cfg2_q <= cfg2_d;
      ee_erase_q <= !cfg1_q[B_DPROT] && cfg1_d[B_DPROT];
      pg_erase_q <= !cfg1_q[B_PPROT] && cfg1_d[B_PPROT];
      if (pwr_we && be_lo[0]) sbor_q <= wdata_q[B_SBOR];
      if (do_write && awaddr_q == A_WDC && be_lo[0]) swdt_q <= wdata_q[0];
      if (do_write && awaddr_q == A_UNLK && be_lo[0]) unlock_q <= wdata_q[0];
      // Hardware clearing of a flag wins over a software set in the same cycle
      if (power_on_event) porf_q <= 1'b0;
      else if (pwr_we && be_lo[0] && wdata_q[B_PORF]) porf_q <= 1'b1;
      if (bor_trip) borf_q <= 1'b0;
      else if (pwr_we && be_lo[0] && wdata_q[B_BORF]) borf_q <= 1'b1;
    end
  end

  // Sequencer, pin filter and power-up timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_RESET;
      pin_cnt_q <= 7'h00;
      pin_rst_q <= 1'b0;
      lf_cnt_q <= 12'h000;
      put_cnt_q <= 12'h000;
      cause_put_q <= 1'b1;
      cause_q <= 2'h0;
    end else begin
      state_q <= state_d;
      pin_cnt_q <= pin_cnt_d;
      pin_rst_q <= pin_low && pin_full;
      lf_cnt_q <= lf_tick ? 12'h000 : lf_cnt_q + 12'h001;
      if (state_q != ST_PUT) put_cnt_q <= 12'h000;
      else if (lf_tick && !put_done) put_cnt_q <= put_cnt_q + 12'h001;
      if (power_on_event || bor_trip) cause_put_q <= 1'b1;
      else if (state_q == ST_RUN && any_reset) cause_put_q <= 1'b0;
      if (state_q == ST_RUN && any_reset) begin
        cause_q <= power_on_event ? 2'h0 : (bor_trip ? 2'h1 : (pin_rst_q ? 2'h2 : 2'h3));
      end
    end
  end

  // Output flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_rst_n_q <= 1'b0;
      regs_rst_q <= 1'b1;
      ins_hold_q <= 1'b1;
      wake_q <= 1'b0;
      bor_en_q <= 1'b1;
      bor_hi_q <= 1'b1;
      wdt_en_q <= 1'b1;
      osc_stop_q <= 1'b0;
      osc_int_q <= 1'b0;
      osc_clko_q <= 1'b1;
      osc1_io_q <= 1'b0;
      osc2_io_q <= 1'b0;
      swo_q <= 1'b1;
      dprot_q <= 1'b0;
      pprot_q <= 1'b0;
      pullup_q <= 1'b1;
      din_q <= 1'b1;
      wr_ok_q <= 1'b0;
    end else begin
      core_rst_n_q <= state_d == ST_RUN;
      regs_rst_q <= state_d != ST_RUN;
      ins_hold_q <= state_d != ST_RUN && !power_on_event;
      wake_q <= wdt_wake && state_q == ST_RUN;
      bor_en_q <= bor_en_d;
      bor_hi_q <= cfg2_q[B_BORLV];
      wdt_en_q <= wdt_en_d;
      osc_stop_q <= pin_rst_q && (rc_mode || int_mode);
      osc_int_q <= int_mode;
      osc_clko_q <= clko_d;
      osc1_io_q <= osc1_io_d;
      osc2_io_q <= osc2_io_d;
      swo_q <= cfg1_q[B_SWO];
      dprot_q <= !cfg1_q[B_DPROT];
      pprot_q <= !cfg1_q[B_PPROT];
      pullup_q <= pin_is_reset;
      din_q <= pin_is_reset ? 1'b1 : reset_pin_in;
      wr_ok_q <= wr_ok_d;
    end
  end

  // Pin is input only: no reset source ever drives it
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe_n = 1'b1;
  assign s_awready = !aw_have_q && !bvalid_q;
  assign s_wready = !w_have_q && !bvalid_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_arready = !rvalid_q;
  assign s_rvalid = rvalid_q;
  assign s_rresp = rresp_q;
  assign s_rdata = rdata_q;
  assign reset_pin_pullup = pullup_q;
  assign pin_digital_in = din_q;
  assign flash_wr_ok = wr_ok_q;
  assign core_reset_n = core_rst_n_q;
  assign regs_reset = regs_rst_q;
  assign insensitive_hold = ins_hold_q;
  assign watchdog_wake = wake_q;
  assign brownout_enable = bor_en_q;
  assign brownout_level_high = bor_hi_q;
  assign watchdog_enable = wdt_en_q;
  assign osc_stop = osc_stop_q;
  assign osc_internal = osc_int_q;
  assign osc_clkout = osc_clko_q;
  assign osc1_io = osc1_io_q;
  assign osc2_io = osc2_io_q;
  assign clock_switchover_enable = swo_q;
  assign data_read_protect = dprot_q;
  assign prog_read_protect = pprot_q;
  assign eeprom_erase = ee_erase_q;
  assign prog_erase = pg_erase_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_bor_low;
    bor_en_q && !brownout_ok;
  endsequence

  a_bor_mode_off: assert property (bor_mode == 2'h0 && sbor_q |=> !bor_en_q)
    else $error("brown-out enabled in mode 00");
  a_bor_sw_mode: assert property (bor_mode == BOR_SW |=> bor_en_q == $past(sbor_q))
    else $error("software brown-out bit not followed");
  a_data_erase: assert property ($rose(cfg1_q[B_DPROT]) |-> ee_erase_q ##1 !ee_erase_q)
    else $error("data erase pulse missing");
  a_prog_erase: assert property ($rose(cfg1_q[B_PPROT]) |-> pg_erase_q ##1 !pg_erase_q)
    else $error("program erase pulse missing");
  a_pin_plain: assert property (!pin_is_reset |=> !pin_rst_q)
    else $error("reset pin acted while plain input");
  a_pullup_follow: assert property (pin_is_reset |=> pullup_q)
    else $error("pull-up off while pin is reset input");
  a_put_gate: assert property (state_q == ST_PUT |-> $past(put_en))
    else $error("power-up timer ran while disabled");
  a_wdt_force: assert property (cfg1_q[B_WDGCFG] |=> wdt_en_q)
    else $error("watchdog not forced on");
  a_osc_halt: assert property (pin_rst_q && int_mode |=> osc_stop_q)
    else $error("oscillator not stopped under pin reset");
  a_self_write: assert property (!LARGE_ARRAY && swp == 2'b00 && flash_wr_addr <= WL_4K_00 |=> !wr_ok_q)
    else $error("protected flash address allowed");
  a_glitch_pass: assert property ($rose(pin_rst_q) |-> $past(pin_low, 1) && $past(pin_cnt_q) == 7'(GLITCH_CYC))
    else $error("short pin pulse caused reset");
  a_pin_undriven: assert property (reset_pin_oe_n)
    else $error("reset pin driven");
  a_bor_hold: assert property (s_bor_low |=> !core_rst_n_q)
    else $error("left reset below trip level");
  a_wake_keep: assert property (wdt_wake && state_q == ST_RUN && !any_reset |=> !regs_rst_q && wake_q)
    else $error("watchdog wake-up reset registers");
endmodule : cwr_reset_control

/* HANDOVER_unused_marker.sv */
// Spare file that holds no logic
`timescale 1ns/1ps

/* cwr_pin_model.sv */
// Far-side model of the shared reset pin: board driver plus weak pull-up resolution
`timescale 1ns/1ps
module cwr_pin_model (
  // Clock
  input wire logic aclk,
  // Board side
  input wire logic pull_low,
  // Device side
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic reset_pin_pullup,
  // Resolved pin level
  output logic pin_level
);
  logic last_q = 1'h1;
  // An undriven pin without pull-up has no defined level, so it wanders instead of holding
  always_comb begin
    if (!reset_pin_oe_n)
      pin_level = reset_pin_out;
    else if (pull_low)
      pin_level = 1'h0;
    else if (reset_pin_pullup)
      pin_level = 1'h1;
    else
      pin_level = !last_q;
  end
  always @(posedge aclk) last_q <= pin_level;
endmodule : cwr_pin_model

/* tb.sv */
// Self-checking bench for the configuration word reset controller
`timescale 1ns/1ps
module tb;
  import cwr_pkg::*;
  // Short power-up timer keeps the sequence to a few cycles
  localparam int LFD = 2;
  localparam int TKS = 5;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
  logic power_on_event = 1'h0, brownout_ok = 1'h1, sleep_mode = 1'h0, watchdog_timeout = 1'h0, pull_low = 1'h0;
  logic [12:0] flash_wr_addr = 13'h0000;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, reset_pin_in, reset_pin_out, reset_pin_oe_n;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic reset_pin_pullup, pin_digital_in, flash_wr_ok, core_reset_n, regs_reset, insensitive_hold, watchdog_wake;
  logic brownout_enable, brownout_level_high, watchdog_enable, osc_stop, osc_internal, osc_clkout, osc1_io, osc2_io;
  logic clock_switchover_enable, data_read_protect, prog_read_protect, eeprom_erase, prog_erase;
  int num_errors = 0, n_checks = 0, n_ee = 0, n_pe = 0, n_drv = 0;
  logic [3:0] osc_tab [5] = '{4'h1, 4'hB, 4'hE, 4'h1, 4'h4};
  logic [12:0] lim_tab [4] = '{WL_4K_00, WL_4K_01, WL_10, 13'h0000};

  cwr_reset_control #(.LARGE_ARRAY(1'h0), .LF_DIV_P(LFD), .PUT_TICKS_P(TKS)) cwr_reset_control_inst (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .reset_pin_in, .reset_pin_out, .reset_pin_oe_n, .reset_pin_pullup, .pin_digital_in,
    .power_on_event, .brownout_ok, .sleep_mode, .watchdog_timeout, .flash_wr_addr, .flash_wr_ok,
    .core_reset_n, .regs_reset, .insensitive_hold, .watchdog_wake, .brownout_enable, .brownout_level_high,
    .watchdog_enable, .osc_stop, .osc_internal, .osc_clkout, .osc1_io, .osc2_io, .clock_switchover_enable,
    .data_read_protect, .prog_read_protect, .eeprom_erase, .prog_erase);
  cwr_pin_model cwr_pin_model_inst (.aclk(aclk), .pull_low(pull_low), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n(reset_pin_oe_n), .reset_pin_pullup(reset_pin_pullup), .pin_level(reset_pin_in));

  always #(CLK_NS / 2.0) aclk = ~aclk;

  // Erase pulses last one cycle, so they are counted mid-cycle rather than polled
  always @(negedge aclk) begin
    if (eeprom_erase === 1'h1) n_ee++;
    if (prog_erase === 1'h1) n_pe++;
    if (reset_pin_oe_n !== 1'h1) n_drv++;
  end

  task close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task tmo;
    num_errors++;
    $display("wrong value at %0t ns: wait ran out", $time);
    close_out();
  endtask : tmo

  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    int i;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      #1;
      aw = s_awvalid && s_awready;
      w = s_wvalid && s_wready;
      b = s_bvalid;
      r = s_bresp;
      @(posedge aclk);
      if (aw) s_awvalid <= 1'h0;
      if (w) s_wvalid <= 1'h0;
      if (b) break;
    end
    s_bready <= 1'h0;
    if (i == 50) tmo();
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, b;
    int i;
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      #1;
      ar = s_arvalid && s_arready;
      b = s_rvalid;
      d = s_rdata;
      r = s_rresp;
      @(posedge aclk);
      if (ar) s_arvalid <= 1'h0;
      if (b) break;
    end
    s_rready <= 1'h0;
    if (i == 50) tmo();
    @(posedge aclk);
  endtask : rd

  // Configuration words only take a write behind the programmer gate
  task automatic cfg(input logic [7:0] a, input logic [13:0] v);
    logic [1:0] r;
    wr(A_UNLK, 32'h1, r);
    wr(a, {18'h0, v}, r);
    cyc(2);
  endtask : cfg

  // Collects {regs_reset, insensitive_hold, watchdog_wake, core in reset, osc_stop} over n cycles
  task automatic watch(input int n, output logic [4:0] s);
    s = 5'h00;
    repeat (n) begin
      #1;
      s |= {regs_reset, insensitive_hold, watchdog_wake, !core_reset_n, osc_stop};
      @(posedge aclk);
    end
  endtask : watch

  task automatic waitrun(output int n);
    for (n = 0; n < 300; n++) begin
      #1;
      if (core_reset_n === 1'h1) break;
      @(posedge aclk);
    end
    if (n == 300) tmo();
    @(posedge aclk);
  endtask : waitrun

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    chk(brownout_enable, 1'h1);
    chk({brownout_level_high, watchdog_enable, osc_clkout, clock_switchover_enable}, 4'hF);
    chk({reset_pin_pullup, data_read_protect, prog_read_protect}, 3'h4);
    rd(A_CFG1, d, r);
    chk(d, 32'h3FFF);
    rd(A_CFG2, d, r);
    chk(d, 32'h3FFF);
    rd(A_PWR, d, r);
    chk(d[B_SBOR], SBOR_RST);
    wr(A_CFG1, 32'h0, r);
    rd(A_CFG1, d, r);
    chk(d, 32'h3FFF);
    rd(8'h40, d, r);
    chk({r, d[7:0]}, 10'h200);
    wr(8'h40, 32'h1, r);
    chk(r, 2'h2);
    rd(A_STAT, d, r);
    chk(d[3:0], 4'hB);
  endtask : t_regs

  task automatic t_wdog;
    logic [1:0] r;
    cfg(A_CFG1, 14'h3BF5);
    chk({clock_switchover_enable, watchdog_enable}, 2'h0);
    wr(A_WDC, 32'h1, r);
    cyc(2);
    chk(watchdog_enable, 1'h1);
    wr(A_WDC, 32'h0, r);
    cfg(A_CFG1, 14'h3BFD);
    chk(watchdog_enable, 1'h1);
  endtask : t_wdog

  task automatic t_bor;
    logic [1:0] r;
    logic [4:0] s;
    int n;
    for (int m = 0; m < 4; m++) begin
      cfg(A_CFG1, 14'(14'h38FD | (m << 8)));
      for (int k = 0; k < 4; k++) begin
        sleep_mode <= k[1];
        wr(A_PWR, k[0] << B_SBOR, r);
        cyc(2);
        chk(brownout_enable, m == 3 || (m == 2 && !k[1]) || (m == 1 && k[0]));
      end
      sleep_mode <= 1'h0;
      wr(A_PWR, 32'h10, r);
      if (m == 0 || m == 3) begin
        brownout_ok <= 1'h0;
        watch(20, s);
        chk(s[1], m == 3);
        brownout_ok <= 1'h1;
        waitrun(n);
      end
    end
  endtask : t_bor

  task automatic t_prot;
    int e0, p0;
    e0 = n_ee;
    p0 = n_pe;
    cfg(A_CFG1, 14'h3F3D);
    chk({data_read_protect, prog_read_protect}, 2'h3);
    cfg(A_CFG1, 14'h3F7D);
    chk({data_read_protect, prog_read_protect}, 2'h2);
    chk(n_pe - p0, 32'h1);
    chk(n_ee - e0, 32'h0);
    cfg(A_CFG1, 14'h3FFD);
    chk(n_ee - e0, 32'h1);
    chk(data_read_protect, 1'h0);
  endtask : t_prot

  task automatic t_osc;
    for (int o = 3; o < 8; o++) begin
      cfg(A_CFG1, 14'(14'h3FF8 | o));
      chk({osc_internal, osc_clkout, osc1_io, osc2_io}, osc_tab[o - 3]);
    end
  endtask : t_osc

  task automatic t_wrt;
    logic [12:0] a [4];
    for (int w = 0; w < 4; w++) begin
      cfg(A_CFG2, {3'h7, w[1:0], w[0], 8'hFF});
      chk(brownout_level_high, w[0]);
      a = '{13'h0000, lim_tab[w], lim_tab[w] + 13'h0001, TOP_4K};
      for (int j = 0; j < 4; j++) begin
        flash_wr_addr <= a[j];
        cyc(2);
        chk(flash_wr_ok, w == 3 || j > 1);
      end
    end
    cfg(A_CFG2, 14'h3FFF);
  endtask : t_wrt

  task automatic t_pin;
    logic [4:0] s, t;
    int n;
    cfg(A_CFG1, 14'h3FFD);
    chk(reset_pin_pullup, 1'h1);
    pull_low <= 1'h1;
    watch(70, s);
    pull_low <= 1'h0;
    watch(10, t);
    chk(s[1] | t[1], 1'h0);
    for (int e = 0; e < 2; e++) begin
      if (e == 1) cfg(A_CFG1, 14'h3FFB);
      pull_low <= 1'h1;
      watch(100, s);
      chk(s[1], 1'h1);
      chk(s[0], e == 0);
      chk(s[4:3], 2'h3);
      pull_low <= 1'h0;
      waitrun(n);
    end
    cfg(A_CFG1, 14'h3FDD);
    chk(reset_pin_pullup, 1'h0);
    pull_low <= 1'h1;
    watch(100, s);
    chk(s[1], 1'h0);
    chk(pin_digital_in, 1'h0);
    pull_low <= 1'h0;
    cfg(A_CFG1, 14'h3FFD);
  endtask : t_pin

  task automatic t_wdt;
    logic [4:0] s;
    int n;
    for (int k = 0; k < 2; k++) begin
      sleep_mode <= k[0];
      cyc(1);
      watchdog_timeout <= 1'h1;
      cyc(1);
      watchdog_timeout <= 1'h0;
      watch(10, s);
      chk(s[4:2], k ? 3'h1 : 3'h6);
      sleep_mode <= 1'h0;
      waitrun(n);
    end
    chk(n_drv, 32'h0);
  endtask : t_wdt

  task automatic t_por;
    logic [4:0] s;
    int n;
    for (int p = 0; p < 2; p++) begin
      cfg(A_CFG1, p ? 14'h3FFD : 14'h3FED);
      power_on_event <= 1'h1;
      watch(3, s);
      power_on_event <= 1'h0;
      chk(s[4:3], 2'h2);
      waitrun(n);
      chk(n >= LFD * TKS, p == 0);
    end
  endtask : t_por

  initial begin
    int n;
    cyc(2);
    aresetn <= 1'h1;
    waitrun(n);
    t_regs();
    t_wdog();
    t_bor();
    t_prot();
    t_osc();
    t_wrt();
    t_pin();
    t_wdt();
    t_por();
    close_out();
  end
endmodule : tb
